// ### rtl/host_port_top.sv
// parallel host port, status flags, interrupt, clock multiplier and system pins
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] non-mux: address strobe pin is address bit 7
// [R2] mux: address latched on strobe rising edge
// [R3] eight-bit bidirectional data bus, bit 7 high
// [R4] strobes ignored unless device select low
// [R5] drive read data while read and select low
// [R6] write captured on write strobe rising edge
// [R7] interrupt low while any unmasked event pending
// [R8] system ties bus multiplex select per bus
// [R9] style select swaps strobe pin meanings
// [R10] block select picks mapped octal port group
// [R11] output clock sixteen times reference clock; code gives 16x only for reference periods of 32 to 255 clk cycles
// [R12] system supplies core clock at least 10x
// [R13] system reset low returns registers to defaults
// [R14] divide 8 kHz reference by 8000 for pulse
// [R15] rising external input sets event flag
// [R16] external inputs 1-8 map to ports 1-8
// [R17] event interrupts only when enable bit set
// [R18] loss output follows status bit 2
// [R19] test mode selects reference as core clock
// [R20] test with reset low floats all outputs
// [R21] direction high reads, low writes, with strobe
module host_port_top
  import host_port_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire host_pins_t           host_in,
  input  wire logic                 bus_mux_select,
  input  wire logic                 bus_style_select,
  input  wire logic                 octal_block_select,
  input  wire logic                 sys_reset_n,
  input  wire logic                 test_mode,
  input  wire logic                 ref_clock_in,
  input  wire logic                 frame_rate_ref_in,
  input  wire logic [PORTS-1:0]     ext_status_in,
  input  wire logic [ALL_PORTS-1:0] delineation_loss_flag,
  output logic [7:0]                data_out,
  output logic                      data_oe_n,
  output logic                      irq_n_out,
  output logic                      irq_n_oe_n,
  output logic                      multiplied_clock_out,
  output logic                      one_second_pulse_out,
  output logic [ALL_PORTS-1:0]      rx_delineation_loss_out,
  output logic                      pins_oe_n,
  output logic                      core_clock_from_ref
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every pin is asynchronous to clk
  localparam int SW = $bits(host_pins_t) + 7 + PORTS + ALL_PORTS;

  logic [SW-1:0] meta_ff;
  logic [SW-1:0] sync_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {host_in, bus_mux_select, bus_style_select, octal_block_select,
                  sys_reset_n, test_mode, ref_clock_in, frame_rate_ref_in,
                  ext_status_in, delineation_loss_flag};
      sync_ff <= meta_ff;
    end
  end

  host_pins_t           hp;
  logic                 mux_q;
  logic                 style_q;
  logic                 blk_q;
  logic                 sysrst_n_q;
  logic                 test_q;
  logic                 ref_q;
  logic                 frame_q;
  logic [PORTS-1:0]     ext_q;
  logic [ALL_PORTS-1:0] loss_q;

  assign {hp, mux_q, style_q, blk_q, sysrst_n_q, test_q, ref_q, frame_q, ext_q,
          loss_q} = sync_ff;

  // sync reset reads low for two cycles after rst, so no access slips through
  logic sys_rst;
  assign sys_rst = !sysrst_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised levels
  localparam int EW = 5 + PORTS;

  logic [EW-1:0] edge_src;
  logic [EW-1:0] prev_ff;
  logic [EW-1:0] rise;

  assign edge_src = {hp.ale, hp.wr_n, hp.rd_n, ref_q, frame_q, ext_q};
  assign rise     = edge_src & ~prev_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= '1;
    end else begin
      prev_ff <= edge_src;
    end
  end

  logic             ale_rise;
  logic             wr_rise;
  logic             strobe_rise;
  logic             ref_rise;
  logic             frame_rise;
  logic [PORTS-1:0] ext_rise;

  assign {ale_rise, wr_rise, strobe_rise, ref_rise, frame_rise, ext_rise} = rise;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [7:0] addr_lat_ff;
  logic [7:0] addr;
  logic       read_act;
  logic       write_ev;
  logic       dec_status;
  logic       dec_rxctl;
  logic [3:0] port_idx;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_lat_ff <= 8'h00;
    end else if (mux_q && ale_rise) begin
      addr_lat_ff <= hp.ad; // [R2]
    end
  end

  assign addr = mux_q ? addr_lat_ff : {hp.ale, hp.addr}; // [R1]

  // style high: rd_n is the data strobe, wr_n the direction (high reads)
  always_comb begin
    if (style_q) begin
      read_act = !hp.cs_n && !hp.rd_n && hp.wr_n; // [R9] [R21]
      write_ev = !hp.cs_n && strobe_rise && !hp.wr_n; // [R21]
    end else begin
      read_act = !hp.cs_n && !hp.rd_n; // [R4] [R9]
      write_ev = !hp.cs_n && wr_rise; // [R4] [R6]
    end
    read_act = read_act && !sys_rst;
    write_ev = write_ev && !sys_rst;
  end

  assign dec_status = (addr[7:3] == STATUS_BASE[7:3]);
  assign dec_rxctl  = (addr[7:3] == RXCTL2_BASE[7:3]);
  assign port_idx   = {blk_q, addr[2:0]}; // [R10]

  //////////////////////////////////////////////////////////////////////////////
  // external event flags: only ports 1..8 of block 0 have an input
  logic [PORTS-1:0] ext_flag_ff;

  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_ext
      logic clr;
      assign clr = write_ev && dec_status && !blk_q && addr[2:0] == 3'(gi) && hp.ad[EXT_BIT];

      // a new edge beats a clear in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ext_flag_ff[gi] <= 1'b0;
        end else if (sys_rst) begin
          ext_flag_ff[gi] <= 1'b0; // [R13]
        end else if (ext_rise[gi]) begin
          ext_flag_ff[gi] <= 1'b1; // [R15] [R16]
        end else if (clr) begin
          ext_flag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // receive control register two, one per port of both octal groups
  logic [ALL_PORTS-1:0][7:0] rx_control_reg_two_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_control_reg_two_ff <= {ALL_PORTS{RXCTL2_RST}};
    end else if (sys_rst) begin
      rx_control_reg_two_ff <= {ALL_PORTS{RXCTL2_RST}}; // [R13]
    end else if (write_ev && dec_rxctl) begin
      rx_control_reg_two_ff[port_idx] <= hp.ad; // [R6]
    end
  end

  logic [PORTS-1:0] external_event_irq_enable;
  logic             irq_pend;

  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      external_event_irq_enable[i] = rx_control_reg_two_ff[i][IRQEN_BIT];
    end
  end

  assign irq_pend = |(ext_flag_ff & external_event_irq_enable); // [R17]

  //////////////////////////////////////////////////////////////////////////////
  // read path
  logic [7:0] port_status_reg;
  logic [7:0] rd_mux;

  always_comb begin
    port_status_reg           = 8'h00;
    port_status_reg[LOSS_BIT] = loss_q[port_idx];
    port_status_reg[EXT_BIT]  = !blk_q && ext_flag_ff[addr[2:0]];
    if (dec_status) begin
      rd_mux = port_status_reg;
    end else if (dec_rxctl) begin
      rd_mux = rx_control_reg_two_ff[port_idx];
    end else begin
      rd_mux = UNMAPPED_RD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output drivers; enables are low while driving
  logic                 hiz;
  logic [7:0]           data_out_ff;
  logic                 data_oe_n_ff;
  logic                 irq_n_out_ff;
  logic                 irq_oe_n_ff;
  logic                 pins_oe_n_ff;
  logic [ALL_PORTS-1:0] rx_delineation_loss_out_ff;
  logic                 core_sel_ff;

  assign hiz = test_q && sys_rst; // [R20]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_ff  <= 8'h00;
      data_oe_n_ff <= 1'b1;
    end else begin
      if (read_act) begin
        data_out_ff <= rd_mux; // [R3] [R5]
      end
      data_oe_n_ff <= !read_act || hiz; // [R5] [R20]
    end
  end

  // open drain: only ever pulls low, released once no unmasked event is pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_n_out_ff <= 1'b1;
      irq_oe_n_ff  <= 1'b1;
    end else begin
      irq_n_out_ff <= !irq_pend;
      irq_oe_n_ff  <= !irq_pend || hiz; // [R7]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_oe_n_ff <= 1'b1;
      rx_delineation_loss_out_ff      <= '0;
      core_sel_ff  <= 1'b0;
    end else begin
      pins_oe_n_ff <= hiz; // [R20]
      rx_delineation_loss_out_ff      <= loss_q; // [R18]
      core_sel_ff  <= test_q; // [R19]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock multiplier: measures the reference period in clk cycles and
  // spreads 32 edges over it; limited to one edge per clk, so a T1 reference
  // at this core rate yields a slower clock than sixteen times
  logic [7:0] per_cnt_ff;
  logic [7:0] period_ff;
  logic [8:0] acc_ff;
  logic       mclk_ff;
  logic [9:0] nxt_acc;
  logic [9:0] rem;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_cnt_ff <= 8'h00;
      period_ff  <= 8'h00;
    end else if (ref_rise) begin
      period_ff  <= per_cnt_ff + 8'h01;
      per_cnt_ff <= 8'h00;
    end else if (per_cnt_ff != 8'hFF) begin
      per_cnt_ff <= per_cnt_ff + 8'h01;
    end
  end

  assign nxt_acc = {1'b0, acc_ff} + MUL_STEP;
  assign rem     = nxt_acc - {2'b00, period_ff};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff  <= 9'h000;
      mclk_ff <= 1'b0;
    end else if (period_ff == 8'h00) begin
      acc_ff <= 9'h000;
    end else if (nxt_acc >= {2'b00, period_ff}) begin
      mclk_ff <= !mclk_ff; // [R11]
      acc_ff  <= (rem >= {2'b00, period_ff}) ? 9'(period_ff - 8'h01) : rem[8:0];
    end else begin
      acc_ff <= nxt_acc[8:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-second pulse
  logic sec_pulse;

  sec_pulse_gen u_sec (
    .clk   (clk),
    .rst   (rst),
    .clear (sys_rst),
    .tick  (frame_rise),
    .pulse (sec_pulse)
  );

  logic sec_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_ff <= 1'b0;
    end else begin
      sec_ff <= sec_pulse; // [R14]
    end
  end

  assign data_out                = data_out_ff;
  assign data_oe_n               = data_oe_n_ff;
  assign irq_n_out               = irq_n_out_ff;
  assign irq_n_oe_n              = irq_oe_n_ff;
  assign multiplied_clock_out    = mclk_ff;
  assign one_second_pulse_out    = sec_ff;
  assign rx_delineation_loss_out = rx_delineation_loss_out_ff;
  assign pins_oe_n               = pins_oe_n_ff;
  assign core_clock_from_ref     = core_sel_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_rxctl;
    write_ev && dec_rxctl;
  endsequence

  sequence s_mux_addr;
    mux_q && ale_rise;
  endsequence

  a_write_capture: assert property ( // [R6]
    s_wr_rxctl |=> rx_control_reg_two_ff[$past(port_idx)] == $past(hp.ad))
    else $error("write data not captured");

  // system reset may legally clear the registers while the host is idle
  a_cs_gate: assert property ( // [R4]
    (hp.cs_n && !sys_rst) |=> data_oe_n_ff && $stable(rx_control_reg_two_ff))
    else $error("access taken without device select");

  a_read_drive: assert property ( // [R5]
    read_act |=> !data_oe_n_ff && data_out_ff == $past(rd_mux))
    else $error("read data not driven");

  a_mux_latch: assert property ( // [R2]
    s_mux_addr |=> addr_lat_ff == $past(hp.ad))
    else $error("multiplexed address not latched");

  a_event_set: assert property ( // [R15]
    (|ext_rise && !sys_rst) |=> (ext_flag_ff & $past(ext_rise)) == $past(ext_rise))
    else $error("external edge did not set flag");

  a_irq_level: assert property ( // [R7]
    !hiz |=> irq_oe_n_ff == !$past(irq_pend))
    else $error("interrupt pin disagrees with pending events");

  a_irq_mask: assert property ( // [R17]
    (ext_flag_ff & external_event_irq_enable) == '0 |=> irq_oe_n_ff)
    else $error("masked event raised interrupt");

  a_sys_reset: assert property ( // [R13]
    sys_rst |=> ext_flag_ff == '0 && rx_control_reg_two_ff == {ALL_PORTS{RXCTL2_RST}})
    else $error("system reset left a register set");

  a_test_float: assert property ( // [R20]
    hiz |=> pins_oe_n_ff && data_oe_n_ff && irq_oe_n_ff)
    else $error("outputs driven in test reset");

  a_loss_out: assert property ( // [R18]
    ##1 rx_delineation_loss_out_ff == $past(loss_q))
    else $error("loss output does not follow status");

endmodule : host_port_top
`default_nettype wire

// ### common/host_port_pkg.sv
// shared constants and carrier types for the host port block
package host_port_pkg;

  // host bus pins; rd_n doubles as data_strobe_n, wr_n as read/write direction
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic [6:0] addr;
    logic [7:0] ad;
  } host_pins_t;

  localparam int PORTS     = 8;
  localparam int ALL_PORTS = 16;

  // register map: status at 0x00..0x07, rx control two at 0x10..0x17
  localparam logic [7:0] STATUS_BASE = 8'h00;
  localparam logic [7:0] RXCTL2_BASE = 8'h10;
  localparam int         EXT_BIT     = 0;
  localparam int         LOSS_BIT    = 2;
  localparam int         IRQEN_BIT   = 0;
  localparam logic [7:0] RXCTL2_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // one-second divider: reference edges per pulse
  localparam int          SEC_DIV  = 8000;
  localparam logic [12:0] SEC_LAST = 13'(SEC_DIV - 1);

  // clock multiplier: output edges per reference period (16x, two edges a cycle)
  localparam int         CLK_MUL  = 16;
  localparam logic [9:0] MUL_STEP = 10'(2 * CLK_MUL);

endpackage : host_port_pkg

// ### rtl/sec_pulse_gen.sv
// one-second pulse from the synchronised 8 kHz reference edges
`timescale 1ns/1ps
`default_nettype none
module sec_pulse_gen
  import host_port_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic tick,
  output logic      pulse
);

  logic [12:0] cnt_ff;
  logic        pulse_ff;
  logic [13:0] ticks_ff;

  // pulse stays high for one reference period, then falls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff   <= 13'h0000;
      pulse_ff <= 1'b0;
    end else if (clear) begin
      cnt_ff   <= 13'h0000;
      pulse_ff <= 1'b0;
    end else if (tick) begin
      pulse_ff <= (cnt_ff == SEC_LAST); // [R14]
      cnt_ff   <= (cnt_ff == SEC_LAST) ? 13'h0000 : cnt_ff + 13'h0001;
    end
  end

  assign pulse = pulse_ff;

  // helper: ticks since the previous rising pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ticks_ff <= 14'h0000;
    end else if (clear || (tick && cnt_ff == SEC_LAST)) begin
      ticks_ff <= 14'h0000;
    end else if (tick) begin
      ticks_ff <= ticks_ff + 14'h0001;
    end
  end

  a_sec_period: assert property (@(posedge clk) disable iff (rst) // [R14]
    (tick && !clear && cnt_ff == SEC_LAST) |=> pulse_ff && ($past(ticks_ff) == 14'(SEC_DIV - 1)))
    else $error("one-second pulse not after 8000 reference edges");

endmodule : sec_pulse_gen
`default_nettype wire

// ### dv/host_cpu_model.sv
// host processor model that drives the parallel register port
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
  import host_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       bus_style_select,
  input  wire logic       bus_mux_select,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output var  host_pins_t pins
);
  initial pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, addr: 7'h00, ad: 8'h00};

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // every phase is held 4 cycles because the port sees pins through synchronisers
  task automatic xfer(input logic wrt, input logic [7:0] a, d, input logic cs,
                      output logic [7:0] q, output logic oe);
    @(posedge clk);
    if (bus_mux_select) begin
      pins.ad  <= a;
      pins.ale <= 1'b0;
      cyc(4);
      pins.ale <= 1'b1;
      cyc(4);
    end else begin
      pins.ale  <= a[7];
      pins.addr <= a[6:0];
    end
    // released lines show the inverse, not a stale copy
    pins.ad   <= wrt ? d : ~pins.ad;
    pins.cs_n <= cs;
    pins.wr_n <= bus_style_select ? !wrt : 1'b1;
    cyc(4);
    if (bus_style_select || !wrt) pins.rd_n <= 1'b0;
    else pins.wr_n <= 1'b0;
    cyc(3);
    @(negedge clk);
    q  = data_out;
    oe = data_oe_n;
    @(posedge clk);
    pins.rd_n <= 1'b1;
    if (!bus_style_select) pins.wr_n <= 1'b1;
    // select stays low past the strobe edge so the write is qualified
    cyc(4);
    pins.cs_n <= 1'b1;
    pins.wr_n <= 1'b1;
    pins.ale  <= 1'b0;
    pins.ad   <= ~pins.ad;
    cyc(4);
  endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the host port block
`timescale 1ns/1ps
`default_nettype none
module tb
  import host_port_pkg::*;
();
  logic        clk = 1'b0, rst = 1'b1, sty = 1'b0, mux = 1'b0, blk = 1'b0;
  logic        sys_n = 1'b1, tst = 1'b0, ref_clk = 1'b0, frame = 1'b0;
  logic [7:0]  ext = 8'h00;
  logic [15:0] loss = 16'h0000;
  host_pins_t  host_m, host_w;
  logic [7:0]  data_out;
  logic        data_oe_n, irq_n_out, irq_n_oe_n, mclk, sec, pins_oe_n, core_sel, irq_w;
  logic [15:0] loss_out;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #12.5 clk = ~clk;
  // the data pins carry the device's value whenever it drives them
  always_comb begin
    host_w = host_m;
    if (!data_oe_n) host_w.ad = data_out;
  end
  assign irq_w = irq_n_oe_n ? 1'b1 : irq_n_out; // pull-up on the open-drain line

  host_port_top DUT (.clk(clk), .rst(rst), .host_in(host_w), .bus_mux_select(mux),
    .bus_style_select(sty), .octal_block_select(blk), .sys_reset_n(sys_n),
    .test_mode(tst), .ref_clock_in(ref_clk), .frame_rate_ref_in(frame),
    .ext_status_in(ext), .delineation_loss_flag(loss), .data_out(data_out),
    .data_oe_n(data_oe_n), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
    .multiplied_clock_out(mclk), .one_second_pulse_out(sec),
    .rx_delineation_loss_out(loss_out), .pins_oe_n(pins_oe_n),
    .core_clock_from_ref(core_sel));

  host_cpu_model HOST (.clk(clk), .bus_style_select(sty), .bus_mux_select(mux),
    .data_out(data_out), .data_oe_n(data_oe_n), .pins(host_m));

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : look

  task automatic mode(input logic s, m);
    @(posedge clk);
    sty <= s;
    mux <= m;
    repeat (4) @(posedge clk);
  endtask : mode

  task automatic wr(input logic [7:0] a, d, input logic cs = 1'b0);
    logic [7:0] q;
    logic       oe;
    HOST.xfer(1'b1, a, d, cs, q, oe);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input logic cs = 1'b0);
    logic [7:0] q;
    logic       oe;
    HOST.xfer(1'b0, a, 8'h00, cs, q, oe);
    chk(oe, cs, "bus drive");
    if (!cs) chk(q, e, "read data");
    chk(data_oe_n, 1'b1, "bus released");
  endtask : rd

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      mode(i[1], i[0]);
      wr(8'h10 + 8'(i), 8'hA5 ^ 8'(i));
      rd(8'h10 + 8'(i), 8'hA5 ^ 8'(i));
    end
    mode(1'b0, 1'b0);
    rd(8'h90, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h11, 8'hFF, 1'b1);
    rd(8'h11, 8'hA4);
    rd(8'h11, 8'h00, 1'b1);
    blk <= 1'b1;
    wr(8'h10, 8'h3C);
    rd(8'h10, 8'h3C);
    blk <= 1'b0;
    rd(8'h10, 8'hA5);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ext();
    wr(8'h13, 8'h01);
    ext <= 8'h08;
    look(8);
    chk(irq_w, 1'b0, "irq raised");
    rd(8'h03, 8'h01);
    wr(8'h03, 8'h01);
    look(1);
    chk(irq_w, 1'b1, "irq cleared");
    rd(8'h03, 8'h00);
    // port 3 stays high: a level must not set the flag again
    ext <= 8'h28;
    look(8);
    rd(8'h05, 8'h01);
    rd(8'h03, 8'h00);
    chk(irq_w, 1'b1, "masked event");
    ext <= 8'h00;
    $display("test events done");
  endtask : t_ext

  task automatic t_loss();
    @(posedge clk);
    loss <= 16'h8004;
    look(6);
    chk(loss_out, 16'h8004, "loss pins");
    rd(8'h02, 8'h04);
    blk <= 1'b1;
    rd(8'h07, 8'h04);
    blk <= 1'b0;
    loss <= 16'h0000;
    $display("test loss done");
  endtask : t_loss

  task automatic t_mul();
    int   n = 0;
    logic last = 1'b0;
    // slow reference so the 32 edges a period are not capped by the core clock
    for (int i = 0; i < 1280; i++) begin
      @(posedge clk);
      if (i % 64 == 0) ref_clk <= ~ref_clk;
      @(negedge clk);
      if (i >= 256 && mclk !== last) n++;
      last = mclk;
    end
    chk(16'(n >= 252 && n <= 260), 16'h0001, "multiplier edges");
    $display("test multiplier done, %0d edges", n);
  endtask : t_mul

  task automatic t_sec();
    int hi = 0;
    for (int i = 1; i <= 8000; i++) begin
      @(posedge clk);
      frame <= 1'b1;
      repeat (2) @(posedge clk);
      frame <= 1'b0;
      @(negedge clk);
      if (i < 8000 && sec !== 1'b0) hi++;
    end
    chk(16'(hi), 16'h0000, "early pulse");
    look(3);
    chk(sec, 1'b1, "second pulse");
    $display("test second done");
  endtask : t_sec

  task automatic t_test();
    @(posedge clk);
    tst <= 1'b1;
    look(5);
    chk({core_sel, pins_oe_n}, 2'b10, "test clock select");
    @(posedge clk);
    sys_n <= 1'b0;
    look(6);
    chk({pins_oe_n, data_oe_n, irq_n_oe_n}, 3'b111, "all float");
    @(posedge clk);
    tst <= 1'b0;
    look(5);
    chk({core_sel, pins_oe_n}, 2'b00, "pins back");
    @(posedge clk);
    sys_n <= 1'b1;
    look(5);
    rd(8'h10, 8'h00);
    $display("test system done");
  endtask : t_test

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    look(6);
    chk({data_oe_n, irq_w}, 2'b11, "reset idle");
    rd(8'h14, 8'h00);
    t_regs();
    t_ext();
    t_loss();
    t_mul();
    t_sec();
    t_test();
    close_out();
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    $display("[FAIL] t=%0t run limit reached", $time);
    close_out();
  end
endmodule : tb
`default_nettype wire
